// ===== logic/coarse_mixer_seq.sv
// fixed-frequency coarse mixer: sign and swap sequences over four sample phases
`timescale 1ns/10ps
`default_nettype none
module coarse_mixer_seq (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic [3:0] mode_i,
   input wire dac_dp_pkg::sample_pair_t din_i,
   output dac_dp_pkg::sample_pair_t dout_o
);
   dac_dp_pkg::mix_phase_t ph_q;
   dac_dp_pkg::sample_pair_t y;
   logic even;

   // one's complement negation: cheap and never overflows, costs one lsb of offset
   function automatic logic [15:0] sgn(input logic [15:0] x, input logic n);
      sgn = n ? ~x : x;
   endfunction

   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin // R16
         ph_q <= dac_dp_pkg::PH0;
      end else begin
         case (ph_q)
            dac_dp_pkg::PH0: ph_q <= dac_dp_pkg::PH1;
            dac_dp_pkg::PH1: ph_q <= dac_dp_pkg::PH2;
            dac_dp_pkg::PH2: ph_q <= dac_dp_pkg::PH3;
            default: ph_q <= dac_dp_pkg::PH0;
         endcase
      end
   end

   always_comb begin
      even = (ph_q == dac_dp_pkg::PH0) || (ph_q == dac_dp_pkg::PH2);
      y = din_i;
      case (mode_i[3:2])
         2'b01: begin
            y.a = sgn(din_i.a, even ^ mode_i[1]); // R5
            y.b = sgn(din_i.b, even ^ mode_i[0]); // R5
         end
         2'b10: begin
            case (ph_q)
               dac_dp_pkg::PH1: begin
                  y.a = ~din_i.b; // R6
                  y.b = din_i.a;
               end
               dac_dp_pkg::PH2: begin
                  y.a = ~din_i.a;
                  y.b = ~din_i.b;
               end
               dac_dp_pkg::PH3: begin
                  y.a = din_i.b;
                  y.b = ~din_i.a;
               end
               default: y = din_i;
            endcase
            y.a = sgn(y.a, mode_i[1]); // R6
            y.b = sgn(y.b, mode_i[0]); // R6
         end
         2'b11: begin
            case (ph_q)
               dac_dp_pkg::PH1: begin
                  y.a = din_i.b; // R7
                  y.b = ~din_i.a;
               end
               dac_dp_pkg::PH2: begin
                  y.a = ~din_i.a;
                  y.b = ~din_i.b;
               end
               dac_dp_pkg::PH3: begin
                  y.a = ~din_i.b;
                  y.b = din_i.a;
               end
               default: y = din_i;
            endcase
            y.a = sgn(y.a, mode_i[1]); // R7
            y.b = sgn(y.b, mode_i[0]); // R7
         end
         default: y = din_i; // R4
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_o <= '0;
      end else begin
         dout_o <= y;
      end
   end
endmodule
`default_nettype wire

// ===== logic/dac_datapath_config_regs.sv
// datapath configuration register bank with the sample path it steers
//
// Overview of operation
// [R1] oscillator runs only while its enable bit is set; mixer control resets to 0x80
// [R2] oscillator gain bit doubles the oscillator mixer output amplitude
// [R3] quadrature gain and phase correction applies only while its enable bit is set
// [R4] coarse mixer passes both channels when mode upper bits are 00
// [R5] modes 01xx alternate each channel's sign per clock; bits 1/0 pick start signs
// [R6] modes 10xx run +A,-B,-A,+B and +B,+A,-B,-A; bits 1/0 negate
// [R7] modes 11xx run +A,+B,-A,-B and +B,-A,-B,+A; bits 1/0 negate
// [R8] inverse-sinc filter is inserted only while its enable bit is set
// [R9] serial port uses four-pin mode when set, three-pin bidirectional when clear
// [R10] fixed-data bit replaces both channels with the 16-bit fixed sample registers
// [R11] half-rate mode takes channel A samples from both input buses alternately
// [R12] upper-sideband bit inverts channel B data before conversion
// [R13] counter-mode field selects an internal counter pattern as the data source
// [R14] divider-restart bit lets a restart-pin rising edge initialise the clock divider
// [R15] oscillator-restart bit lets a restart-pin rising edge clear the phase accumulator
// [R16] mixer-restart bit lets a restart-pin rising edge restart the mixer sequence
// [R17] a three-bit field picks the rising-edge, write-strobe or constant source that resets the fifo pointers
// [R18] software leaves the factory stage-skip register at zero
// [R19] 32-bit oscillator step word from bytes at 0x09, 0x0a, 0x0c, 0x0b
// [R20] 16-bit oscillator phase offset from 0x0d low and 0x0e high
// [R21] 13-bit offsets; correction and offset writes wait for a write to 0x0f
// [R22] 11-bit correction gains and 10-bit phase; 0x16 holds their upper bits
`timescale 1ns/10ps
`default_nettype none
`include "dac_dp_consts.svh"
module dac_datapath_config_regs (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic REG_WE_I,
   input wire logic [4:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   output logic [7:0] REG_RDATA_O,
   input wire logic [15:0] PORT_A_INPUT_BUS_I,
   input wire logic [15:0] PORT_B_INPUT_BUS_I,
   input wire logic TX_ENABLE_I,
   input wire logic PHASE_RESTART_I,
   input wire logic Q_FLAG_I,
   output logic [15:0] DAC_A_O,
   output logic [15:0] DAC_B_O,
   output logic FOUR_WIRE_PORT_SELECT_O,
   output logic NCO_RUN_O,
   output logic NCO_GAIN2_O,
   output logic [15:0] NCO_ANGLE_O,
   output logic QMC_EN_O,
   output logic [10:0] QMC_GAIN_A_O,
   output logic [10:0] QMC_GAIN_B_O,
   output logic [9:0] QMC_ANGLE_O,
   output logic [12:0] DC_SHIFT_A_O,
   output logic [12:0] DC_SHIFT_B_O,
   output logic INVSINC_EN_O,
   output logic [7:0] CHAN_A_SCALE_O,
   output logic [1:0] DIV_PHASE_O,
   output logic [1:0] FIFO_WPTR_O,
   output logic [1:0] FIFO_RPTR_O,
   output logic FIFO_SYNC_O
);
   logic [7:0] reg_q [`A_FIRST:`A_LAST];
   logic [7:0] act_q [`A_OFSB_LO:`A_UPPER];
   logic [3:0] coarse_mixer_select;
   logic four_wire_port_select;
   logic mixer_restart_enable;
   logic nco_en;
   logic fixed_en;
   logic half_en;
   logic usb_en;
   logic [2:0] ctr_mode;
   dac_dp_pkg::fifo_src_t fifo_src;
   logic [31:0] step_word;
   logic [15:0] angle_word;
   logic [15:0] fixed_word;
   logic phr_q;
   logic txen_q;
   logic qflag_q;
   logic bmsb_q;
   logic amsb_q;
   logic amsb_done_q;
   logic phr_rise;
   logic fifo_sync;
   logic [31:0] acc_q;
   logic [15:0] ctr_q;
   logic half_sel_q;
   dac_dp_pkg::sample_pair_t src;
   dac_dp_pkg::sample_pair_t src_q;
   dac_dp_pkg::sample_pair_t mix_out;

   // address lies inside the implemented window
   function automatic logic in_map(input logic [4:0] a);
      in_map = (a >= `A_FIRST) && (a <= `A_LAST);
   endfunction

   function automatic logic [7:0] rst_val(input logic [4:0] a);
      case (a)
         `A_MIX: rst_val = `RST_MIX; // R1
         `A_STEP2: rst_val = `RST_STEP2;
         default: rst_val = `RST_ZERO;
      endcase
   endfunction

   // unused bits are never stored, so they read back as zero
   function automatic logic [7:0] wr_mask(input logic [4:0] a);
      case (a)
         `A_FMT: wr_mask = `MASK_FMT;
         `A_RST: wr_mask = `MASK_RST;
         `A_OFSA_HI: wr_mask = `MASK_OFS_HI;
         `A_OFSB_HI: wr_mask = `MASK_OFS_HI;
         default: wr_mask = `MASK_ALL;
      endcase
   endfunction

   // the factory stage-skip register is stored and read back but steers nothing
   for (genvar g = `A_FIRST; g <= `A_LAST; g++) begin : g_reg
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            reg_q[g] <= rst_val(5'(g));
         end else if (REG_WE_I && in_map(REG_ADDR_I) && REG_ADDR_I == 5'(g)) begin
            reg_q[g] <= REG_WDATA_I & wr_mask(5'(g));
         end
      end
   end

   // held copies: correction and offset words change together on the 0x0f write
   for (genvar s = `A_OFSB_LO; s <= `A_UPPER; s++) begin : g_act
      always_ff @(posedge CLK_I) begin
         if (RST_I) begin
            act_q[s] <= `RST_ZERO;
         end else if (REG_WE_I && REG_ADDR_I == `A_OFSA_LO) begin
            act_q[s] <= reg_q[s]; // R21
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         REG_RDATA_O <= '0;
      end else if (in_map(REG_ADDR_I)) begin
         REG_RDATA_O <= reg_q[REG_ADDR_I];
      end else begin
         REG_RDATA_O <= '0;
      end
   end

   always_comb begin
      nco_en = reg_q[`A_MIX][`BIT_NCO];
      coarse_mixer_select = reg_q[`A_MIX][`CM_HI:`CM_LO];
      four_wire_port_select = reg_q[`A_FMT][`BIT_FOUR];
      fixed_en = reg_q[`A_FMT][`BIT_FIXED];
      half_en = reg_q[`A_FMT][`BIT_HALF];
      usb_en = reg_q[`A_FMT][`BIT_USB];
      ctr_mode = reg_q[`A_FMT][`CTR_HI:`CTR_LO];
      mixer_restart_enable = reg_q[`A_RST][`BIT_MIXR];
      fifo_src = dac_dp_pkg::fifo_src_t'(reg_q[`A_RST][`FSRC_HI:`FSRC_LO]);
      step_word = {reg_q[`A_STEP3], reg_q[`A_STEP2], reg_q[`A_STEP1],
                   reg_q[`A_STEP0]}; // R19
      angle_word = {reg_q[`A_ANG_HI], reg_q[`A_ANG_LO]}; // R20
      fixed_word = {reg_q[`A_FIX_HI], reg_q[`A_FIX_LO]}; // R10
   end

   // static settings go out straight from flip-flops
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         FOUR_WIRE_PORT_SELECT_O <= 1'b0;
         NCO_RUN_O <= 1'b0;
         NCO_GAIN2_O <= 1'b0;
         QMC_EN_O <= 1'b0;
         INVSINC_EN_O <= 1'b0;
         CHAN_A_SCALE_O <= '0;
      end else begin
         FOUR_WIRE_PORT_SELECT_O <= four_wire_port_select; // R9
         NCO_RUN_O <= nco_en; // R1
         NCO_GAIN2_O <= reg_q[`A_MIX][`BIT_NCO_GAIN]; // R2
         QMC_EN_O <= reg_q[`A_MIX][`BIT_QMC]; // R3
         INVSINC_EN_O <= reg_q[`A_MIX][`BIT_INVSINC]; // R8
         CHAN_A_SCALE_O <= reg_q[`A_SCALE_A];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         DC_SHIFT_A_O <= '0;
         DC_SHIFT_B_O <= '0;
         QMC_GAIN_A_O <= '0;
         QMC_GAIN_B_O <= '0;
         QMC_ANGLE_O <= '0;
      end else begin
         DC_SHIFT_A_O <= {act_q[`A_OFSA_HI][7:3], reg_q[`A_OFSA_LO]}; // R21
         DC_SHIFT_B_O <= {act_q[`A_OFSB_HI][7:3], act_q[`A_OFSB_LO]}; // R21
         QMC_GAIN_A_O <= {act_q[`A_UPPER][5:3], act_q[`A_GA_LO]}; // R22
         QMC_GAIN_B_O <= {act_q[`A_UPPER][2:0], act_q[`A_GB_LO]}; // R22
         QMC_ANGLE_O <= {act_q[`A_UPPER][7:6], act_q[`A_PH_LO]}; // R22
      end
   end

   // previous levels for edge detection; all inputs arrive synchronous
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         phr_q <= 1'b0;
         txen_q <= 1'b0;
         qflag_q <= 1'b0;
         bmsb_q <= 1'b0;
         amsb_q <= 1'b0;
      end else begin
         phr_q <= PHASE_RESTART_I;
         txen_q <= TX_ENABLE_I;
         qflag_q <= Q_FLAG_I;
         bmsb_q <= PORT_B_INPUT_BUS_I[15];
         amsb_q <= PORT_A_INPUT_BUS_I[15];
      end
   end

   assign phr_rise = PHASE_RESTART_I & ~phr_q;

   // oscillator phase accumulator
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         acc_q <= '0;
      end else if (reg_q[`A_RST][`BIT_OSC] && phr_rise) begin
         acc_q <= '0; // R15
      end else if (nco_en) begin
         acc_q <= acc_q + step_word; // R1
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         NCO_ANGLE_O <= '0;
      end else begin
         NCO_ANGLE_O <= acc_q[31:16] + angle_word; // R20
      end
   end

   // internal clock divider phase
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         DIV_PHASE_O <= '0;
      end else if (reg_q[`A_RST][`BIT_DIV] && phr_rise) begin
         DIV_PHASE_O <= '0; // R14
      end else begin
         DIV_PHASE_O <= DIV_PHASE_O + 2'h1;
      end
   end

   // one shot re-arms on a restart register write; a shot in that same cycle wins
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         amsb_done_q <= 1'b0;
      end else if (fifo_src == dac_dp_pkg::SRC_AMSB_ONCE &&
                   PORT_A_INPUT_BUS_I[15] && !amsb_q) begin
         amsb_done_q <= 1'b1;
      end else if (REG_WE_I && REG_ADDR_I == `A_RST) begin
         amsb_done_q <= 1'b0;
      end
   end

   always_comb begin
      case (fifo_src) // R17
         dac_dp_pkg::SRC_TXEN: fifo_sync = TX_ENABLE_I & ~txen_q;
         dac_dp_pkg::SRC_PHR: fifo_sync = phr_rise;
         dac_dp_pkg::SRC_QFLAG: fifo_sync = Q_FLAG_I & ~qflag_q;
         dac_dp_pkg::SRC_BMSB: fifo_sync = PORT_B_INPUT_BUS_I[15] & ~bmsb_q;
         dac_dp_pkg::SRC_AMSB_ONCE: begin
            fifo_sync = PORT_A_INPUT_BUS_I[15] & ~amsb_q & ~amsb_done_q;
         end
         dac_dp_pkg::SRC_WRITE: fifo_sync = REG_WE_I;
         dac_dp_pkg::SRC_ON: fifo_sync = 1'b1;
         default: fifo_sync = 1'b0;
      endcase
   end

   // four-entry fifo pointers, read side trails write side by half the depth
   always_ff @(posedge CLK_I) begin
      if (RST_I || fifo_sync) begin
         FIFO_WPTR_O <= '0; // R17
         FIFO_RPTR_O <= 2'h0 - `FIFO_RD_LAG;
      end else begin
         FIFO_WPTR_O <= FIFO_WPTR_O + 2'h1;
         FIFO_RPTR_O <= FIFO_RPTR_O + 2'h1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         FIFO_SYNC_O <= 1'b0;
      end else begin
         FIFO_SYNC_O <= fifo_sync;
      end
   end

   // test counter runs only while selected
   always_ff @(posedge CLK_I) begin
      if (RST_I || !ctr_mode[2]) begin
         ctr_q <= '0;
      end else begin
         ctr_q <= ctr_q + 16'h0001; // R13
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I || !half_en) begin
         half_sel_q <= 1'b0;
      end else begin
         half_sel_q <= ~half_sel_q; // R11
      end
   end

   // source select: counter beats fixed data, fixed data beats the input buses
   always_comb begin
      src.a = PORT_A_INPUT_BUS_I;
      src.b = PORT_B_INPUT_BUS_I;
      if (ctr_mode[2]) begin
         case (ctr_mode[1:0]) // R13
            2'b01: src.a = {9'h000, ctr_q[6:0]};
            2'b10: src.a = {5'h00, ctr_q[4:0], 6'h00};
            2'b11: src.a = {ctr_q[4:0], 11'h000};
            default: src.a = ctr_q;
         endcase
         src.b = src.a;
      end else if (fixed_en) begin
         src.a = fixed_word; // R10
         src.b = fixed_word; // R10
      end else if (half_en) begin
         // the A bus carries the even sample, the B bus the odd one
         src.a = half_sel_q ? PORT_B_INPUT_BUS_I : PORT_A_INPUT_BUS_I; // R11
         src.b = '0;
      end
      if (usb_en) begin
         src.b = ~src.b; // R12
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         src_q <= '0;
      end else begin
         src_q <= src;
      end
   end

   coarse_mixer_seq u_mix (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .restart_i(mixer_restart_enable & phr_rise), // R16
      .mode_i(coarse_mixer_select), // R4
      .din_i(src_q),
      .dout_o(mix_out)
   );

   assign DAC_A_O = mix_out.a;
   assign DAC_B_O = mix_out.b;
endmodule
`default_nettype wire

// ===== logic/dac_dp_consts.svh
// offsets, reset values, field positions and masks of the datapath register bank
`ifndef DAC_DP_CONSTS_SVH
`define DAC_DP_CONSTS_SVH
`define A_FIRST 5'h03
`define A_LAST 5'h17
`define A_MIX 5'h03
`define A_FMT 5'h04
`define A_RST 5'h05
`define A_FIX_LO 5'h06
`define A_FIX_HI 5'h07
`define A_SKIP 5'h08
`define A_STEP0 5'h09
`define A_STEP1 5'h0a
`define A_STEP3 5'h0b
`define A_STEP2 5'h0c
`define A_ANG_LO 5'h0d
`define A_ANG_HI 5'h0e
`define A_OFSA_LO 5'h0f
`define A_OFSB_LO 5'h10
`define A_OFSA_HI 5'h11
`define A_OFSB_HI 5'h12
`define A_GA_LO 5'h13
`define A_GB_LO 5'h14
`define A_PH_LO 5'h15
`define A_UPPER 5'h16
`define A_SCALE_A 5'h17
`define RST_MIX 8'h80
`define RST_STEP2 8'h40
`define RST_ZERO 8'h00
`define MASK_ALL 8'hff
`define MASK_FMT 8'hef
`define MASK_RST 8'hfc
`define MASK_OFS_HI 8'hf8
`define BIT_NCO 7
`define BIT_NCO_GAIN 6
`define BIT_QMC 5
`define CM_HI 4
`define CM_LO 1
`define BIT_INVSINC 0
`define BIT_FOUR 7
`define BIT_FIXED 6
`define BIT_HALF 5
`define BIT_USB 3
`define CTR_HI 2
`define CTR_LO 0
`define BIT_DIV 7
`define BIT_OSC 6
`define BIT_MIXR 5
`define FSRC_HI 4
`define FSRC_LO 2
`define CTR_MID_LSB 6
`define FIFO_RD_LAG 2'h2
`endif

// ===== logic/dac_dp_pkg.sv
// types shared by the datapath register bank and its coarse mixer
`default_nettype none
package dac_dp_pkg;
   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
   } sample_pair_t;
   typedef enum logic [3:0] {
      PH0 = 4'b0001,
      PH1 = 4'b0010,
      PH2 = 4'b0100,
      PH3 = 4'b1000
   } mix_phase_t;
   typedef enum logic [2:0] {
      SRC_TXEN = 3'h0,
      SRC_PHR = 3'h1,
      SRC_QFLAG = 3'h2,
      SRC_BMSB = 3'h3,
      SRC_AMSB_ONCE = 3'h4,
      SRC_WRITE = 3'h5,
      SRC_OFF = 3'h6,
      SRC_ON = 3'h7
   } fifo_src_t;
endpackage
`default_nettype wire

// ===== verification/dac_datapath_config_regs_tb.sv
// randomised self-checking bench for the datapath register bank
`timescale 1ns/10ps
`default_nettype none
module dac_datapath_config_regs_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic txen = 1'b0;
   logic phr = 1'b0;
   logic qflag = 1'b0;
   logic [15:0] a_bus = 16'h0000;
   logic [15:0] b_bus = 16'h0000;
   logic [7:0] rv [0:31];
   logic [15:0] cm [0:3] = '{16'h0000, 16'hff80, 16'hf83f, 16'h07ff};
   logic [15:0] stp [0:3] = '{16'h0001, 16'h0001, 16'h0040, 16'h0800};
   logic [2:0] fexp [0:7] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h4};
   int fail_count = 0;
   int checks_done = 0;
   wire logic we, fsync, four_w;
   wire logic [4:0] addr;
   wire logic [7:0] wdata, rdata, scale_a;
   wire logic [15:0] dac_a, dac_b, nco_ang;
   wire logic [12:0] dca, dcb;
   wire logic [10:0] qga, qgb;
   wire logic [9:0] qang;
   wire logic [1:0] divp;
   always #12.5 clk = ~clk;
   host_byte_port host (.clk_i(clk), .rdata_i(rdata), .we_o(we), .addr_o(addr), .wdata_o(wdata));
   dac_datapath_config_regs dut (
      .CLK_I(clk), .RST_I(rst), .REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_RDATA_O(rdata), .PORT_A_INPUT_BUS_I(a_bus), .PORT_B_INPUT_BUS_I(b_bus),
      .TX_ENABLE_I(txen), .PHASE_RESTART_I(phr), .Q_FLAG_I(qflag), .DAC_A_O(dac_a),
      .DAC_B_O(dac_b), .FOUR_WIRE_PORT_SELECT_O(four_w), .NCO_RUN_O(), .NCO_GAIN2_O(),
      .NCO_ANGLE_O(nco_ang), .QMC_EN_O(), .QMC_GAIN_A_O(qga), .QMC_GAIN_B_O(qgb),
      .QMC_ANGLE_O(qang), .DC_SHIFT_A_O(dca), .DC_SHIFT_B_O(dcb), .INVSINC_EN_O(),
      .CHAN_A_SCALE_O(scale_a), .DIV_PHASE_O(divp), .FIFO_WPTR_O(), .FIFO_RPTR_O(),
      .FIFO_SYNC_O(fsync));
   function automatic logic [7:0] rst_val(input logic [4:0] a);
      if (a == 5'h03) return 8'h80;
      if (a == 5'h0c) return 8'h40;
      return 8'h00;
   endfunction
   function automatic logic [7:0] wmask(input logic [4:0] a);
      case (a)
         5'h04: return 8'hef;
         5'h05: return 8'hfc;
         5'h11, 5'h12: return 8'hf8;
         default: return (a >= 5'h03 && a <= 5'h17) ? 8'hff : 8'h00;
      endcase
   endfunction
   // one's complement stands for negation, as the mixer does it
   function automatic logic [31:0] mix(input logic [3:0] m, input logic [15:0] a,
                                       input logic [15:0] b, input int ph);
      logic [15:0] x;
      logic [15:0] y;
      case (m[3:2])
         2'b00: return {a, b};
         2'b01: begin
            x = ph[0] ? ~a : a;
            y = ph[0] ? ~b : b;
            return {m[1] ? x : ~x, m[0] ? y : ~y};
         end
         2'b10: begin
            x = (ph == 0) ? a : (ph == 1) ? ~b : (ph == 2) ? ~a : b;
            y = (ph == 0) ? b : (ph == 1) ? a : (ph == 2) ? ~b : ~a;
         end
         default: begin
            x = (ph == 0) ? a : (ph == 1) ? b : (ph == 2) ? ~a : ~b;
            y = (ph == 0) ? b : (ph == 1) ? ~a : (ph == 2) ? ~b : a;
         end
      endcase
      return {m[1] ? ~x : x, m[0] ? ~y : y};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic w(input logic [4:0] a, input logic [7:0] d);
      rv[a] = d & wmask(a);
      host.wr(a, d);
   endtask
   task automatic pulse;
      @(posedge clk);
      phr <= 1'b1;
      @(posedge clk);
      phr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #500000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      logic [7:0] d;
      logic [15:0] ra, rb, s0;
      int n;
      void'($urandom(11));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 32; i++) begin
         host.rd(i[4:0], d);
         chk(d, rst_val(i[4:0]));
      end
      // the factory register stays untouched
      for (int i = 3; i < 32; i++) begin
         if (i != 8) w(i[4:0], 8'($urandom));
         host.rd(i[4:0], d);
         chk(d, (i == 8) ? 8'h00 : rv[i]);
      end
      chk(four_w, rv[4][7]);
      chk(scale_a, rv[23]);
      for (int i = 16; i < 23; i++) w(i[4:0], 8'($urandom));
      w(5'h0f, 8'($urandom));
      repeat (3) @(posedge clk);
      chk(dca, {rv[17][7:3], rv[15]});
      chk(dcb, {rv[18][7:3], rv[16]});
      chk(qga, {rv[22][5:3], rv[19]});
      chk(qgb, {rv[22][2:0], rv[20]});
      chk(qang, {rv[22][7:6], rv[21]});
      w(5'h03, 8'h00);
      w(5'h05, 8'h40);
      w(5'h0d, 8'($urandom));
      w(5'h0e, 8'($urandom));
      pulse();
      repeat (3) @(posedge clk);
      chk(nco_ang, {rv[14], rv[13]});
      for (int i = 9; i < 13; i++) w(i[4:0], (i == 12) ? 8'h01 : 8'h00);
      for (int e = 1; e >= 0; e--) begin
         w(5'h03, {e[0], 7'h00});
         repeat (3) @(posedge clk);
         s0 = nco_ang;
         @(posedge clk);
         chk(nco_ang - s0, {15'h0000, e[0]});
      end
      w(5'h04, 8'h00);
      w(5'h05, 8'ha0);
      for (int m = 0; m < 16; m++) begin
         ra = 16'($urandom);
         rb = 16'($urandom);
         a_bus <= ra;
         b_bus <= rb;
         w(5'h03, {3'b000, m[3:0], 1'b0});
         pulse();
         chk(divp, 2'h0);
         n = 0;
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            n += ({dac_a, dac_b} === mix(m[3:0], ra, rb, k)) ? 1 : 0;
         end
         chk(n[2:0], 3'h4);
      end
      w(5'h03, 8'h00);
      w(5'h04, 8'h08);
      repeat (4) @(posedge clk);
      chk(dac_a, a_bus);
      chk(dac_b, ~b_bus);
      w(5'h06, 8'($urandom));
      w(5'h07, 8'($urandom));
      w(5'h04, 8'h40);
      repeat (4) @(posedge clk);
      chk(dac_a, {rv[7], rv[6]});
      chk(dac_b, {rv[7], rv[6]});
      w(5'h04, 8'h20);
      repeat (4) @(posedge clk);
      s0 = dac_a;
      @(posedge clk);
      chk((s0 === a_bus && dac_a === b_bus) || (s0 === b_bus && dac_a === a_bus), 1'b1);
      chk(dac_b, 16'h0000);
      for (int c = 0; c < 4; c++) begin
         w(5'h04, {6'b000001, c[1:0]});
         repeat (4) @(posedge clk);
         s0 = dac_a;
         @(posedge clk);
         chk(s0 & cm[c], 16'h0000);
         chk((dac_a - s0) & ~cm[c], stp[c]);
      end
      w(5'h04, 8'h00);
      a_bus <= 16'h0000;
      b_bus <= 16'h0000;
      for (int s = 0; s < 8; s++) begin
         w(5'h05, {3'b000, s[2:0], 2'b00});
         repeat (4) @(posedge clk);
         n = 0;
         case (s)
            0, 6: txen <= 1'b1;
            1: phr <= 1'b1;
            2: qflag <= 1'b1;
            3: b_bus <= 16'h8000;
            4: a_bus <= 16'h8000;
            5: w(5'h06, 8'h5a);
            default: ;
         endcase
         for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            n += (fsync === 1'b1) ? 1 : 0;
         end
         chk(n[2:0], fexp[s]);
         txen <= 1'b0;
         phr <= 1'b0;
         qflag <= 1'b0;
         a_bus <= 16'h0000;
         b_bus <= 16'h0000;
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== verification/dac_dp_asserts.sv
// concurrent checks on the datapath register bank ports
`timescale 1ns/10ps
`default_nettype none
module dac_dp_asserts (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic REG_WE_I,
   input wire logic [4:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic PHASE_RESTART_I,
   input wire logic NCO_RUN_O,
   input wire logic NCO_GAIN2_O,
   input wire logic QMC_EN_O,
   input wire logic INVSINC_EN_O,
   input wire logic [12:0] DC_SHIFT_A_O,
   input wire logic [12:0] DC_SHIFT_B_O,
   input wire logic [10:0] QMC_GAIN_A_O,
   input wire logic [10:0] QMC_GAIN_B_O,
   input wire logic [9:0] QMC_ANGLE_O,
   input wire logic [1:0] DIV_PHASE_O,
   input wire logic [1:0] FIFO_WPTR_O,
   input wire logic [1:0] FIFO_RPTR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // mirror of the restart source byte: tells which sync source is live
   logic [7:0] sync_q;
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         sync_q <= 8'h00;
      end else if (REG_WE_I && REG_ADDR_I == 5'h05) begin
         sync_q <= REG_WDATA_I;
      end
   end
   sequence wr_to(logic [4:0] a);
      REG_WE_I && REG_ADDR_I == a;
   endsequence
   sequence phr_rise;
      PHASE_RESTART_I && !$past(PHASE_RESTART_I);
   endsequence
   property copies(logic [4:0] a, logic wb, logic o);
      wr_to(a) |-> ##2 o == $past(wb, 2);
   endproperty
   nco_run_a: assert property (copies(5'h03, REG_WDATA_I[7], NCO_RUN_O))
      else $error("oscillator run flag does not follow its bit");
   nco_gain_a: assert property (copies(5'h03, REG_WDATA_I[6], NCO_GAIN2_O))
      else $error("oscillator gain flag does not follow its bit");
   qmc_en_a: assert property (copies(5'h03, REG_WDATA_I[5], QMC_EN_O))
      else $error("correction enable does not follow its bit");
   invsinc_en_a: assert property (copies(5'h03, REG_WDATA_I[0], INVSINC_EN_O))
      else $error("inverse sinc enable does not follow its bit");
   ofs_low_a: assert property (
      wr_to(5'h0f) |-> ##2 DC_SHIFT_A_O[7:0] == $past(REG_WDATA_I, 2))
      else $error("offset low byte not applied");
   held_write_a: assert property (REG_WE_I && REG_ADDR_I inside {[5'h10:5'h16]} |-> ##2
      $stable({DC_SHIFT_A_O, DC_SHIFT_B_O, QMC_GAIN_A_O, QMC_GAIN_B_O, QMC_ANGLE_O}))
      else $error("held word changed before the offset low write");
   fifo_soft_a: assert property (
      REG_WE_I && REG_ADDR_I != 5'h05 && sync_q[4:2] == 3'h5 |=> FIFO_WPTR_O == 2'h0
      && FIFO_RPTR_O == 2'h2)
      else $error("write strobe did not restart the fifo pointers");
   div_restart_a: assert property (sync_q[7] ##0 phr_rise |=> DIV_PHASE_O == 2'h0)
      else $error("divider not restarted");
endmodule
bind dac_datapath_config_regs dac_dp_asserts chk (
   .CLK_I(CLK_I), .RST_I(RST_I), .REG_WE_I(REG_WE_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .PHASE_RESTART_I(PHASE_RESTART_I), .NCO_RUN_O(NCO_RUN_O),
   .NCO_GAIN2_O(NCO_GAIN2_O), .QMC_EN_O(QMC_EN_O), .INVSINC_EN_O(INVSINC_EN_O),
   .DC_SHIFT_A_O(DC_SHIFT_A_O), .DC_SHIFT_B_O(DC_SHIFT_B_O), .QMC_GAIN_A_O(QMC_GAIN_A_O),
   .QMC_GAIN_B_O(QMC_GAIN_B_O), .QMC_ANGLE_O(QMC_ANGLE_O), .DIV_PHASE_O(DIV_PHASE_O),
   .FIFO_WPTR_O(FIFO_WPTR_O), .FIFO_RPTR_O(FIFO_RPTR_O)
);
`default_nettype wire

// ===== verification/host_byte_port.sv
// host model on the register byte port: single-byte writes and reads
`timescale 1ns/10ps
`default_nettype none
module host_byte_port (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic we_o,
   output logic [4:0] addr_o,
   output logic [7:0] wdata_o
);
   initial begin
      we_o = 1'b0;
      addr_o = 5'h00;
      wdata_o = 8'h00;
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      we_o <= 1'b1;
      addr_o <= a;
      wdata_o <= (a == 5'h08) ? 8'h00 : d;
      @(posedge clk_i);
      we_o <= 1'b0;
      // released data is scrambled so a late capture cannot pass by luck
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      @(posedge clk_i);
      @(posedge clk_i);
      d = rdata_i;
   endtask
endmodule
`default_nettype wire
